// >>> logic/asc_ctrl.sv
// Host-side controller for an asynchronous 16-bit static memory.
// Assumes the memory data inputs are sampled synchronously to CORE_CLK and
// that board delays are small against one 25 ns cycle.
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"

// Behaviour
// - Write strobe low only while chip select and a lane select are low.
// - Data driven a full cycle before and held through the write-ending edge.
// - Never drive data while the memory may still drive it.
// - Strobe-paced write with output drive low needs release plus setup time.
// - Address stands at least 35 ns before write end, from write start.
// - Address never changes before the write has ended.
// - Chip and lane selects low at least 35 ns before write end.
// - Hold chip select at full high level during retention.
// - Wait 45 ns after retention before any access.
// - Address-paced read keeps selects and output drive low, strobe high.
// - Output-drive read sets address no later than chip and lane selects.
// - Read with chip select and output drive low, write strobe high.
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16,
  parameter int CNT_W = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_BE,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  input wire logic RETAIN_REQ,
  output logic RETAINING,
  output logic [ADDR_W-1:0] SRAM_ADDR,
  output logic SRAM_CHIP_SEL_N,
  output logic SRAM_OUT_DRIVE_N,
  output logic SRAM_WRITE_STROBE_N,
  output logic SRAM_UPPER_BYTE_SEL_N,
  output logic SRAM_LOWER_BYTE_SEL_N,
  output logic [DATA_W-1:0] SRAM_DQ_O,
  output logic SRAM_DQ_OE,
  input wire logic [DATA_W-1:0] SRAM_DQ_I
);
  localparam int HALF_W = DATA_W / 2;

  // Refuse widths the lane logic, the 18-bit memory address or the timer cannot serve
  if (DATA_W != 16) begin : g_bad_data_w
    $error("asc_ctrl: data bus must be 16 bits, two byte lanes");
  end
  if (ADDR_W < 1 || ADDR_W > 18) begin : g_bad_addr_w
    $error("asc_ctrl: address width must lie between 1 and 18");
  end
  if ((1 << CNT_W) <= `ASC_READ_CYC || (1 << CNT_W) <= `ASC_PULSE_CYC ||
      (1 << CNT_W) <= `ASC_RECOV_CYC || (1 << CNT_W) <= `ASC_TURN_CYC) begin : g_bad_cnt_w
    $error("asc_ctrl: timer too narrow for the interval counts");
  end

  typedef struct packed {
    asc_state_t st;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [DATA_W-1:0] rdata;
    logic rsp;
  } asc_ctrl_st_t;

  asc_ctrl_st_t s_r;
  asc_ctrl_st_t s_nxt;

  asc_tmr_if #(.CNT_W(CNT_W)) tif ();

  asc_timer #(.CNT_W(CNT_W)) u_timer (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .tif(tif)
  );

  // Idle and accepting only outside retention
  assign REQ_READY = (s_r.st == ASC_IDLE) && !RETAIN_REQ;

  // Next state and pin values; every pin leaves from a flip-flop
  always_comb begin
    logic [1:0] lanes_n;
    lanes_n = ~REQ_BE;
    s_nxt = s_r;
    s_nxt.rsp = 1'b0;
    tif.load = 1'b0;
    tif.count = CNT_W'(1);
    // A request with no lane would never open a write window, so take both
    if (REQ_BE == 2'h0) begin
      lanes_n = 2'h0;
    end
    case (s_r.st)
      ASC_IDLE: begin
        if (RETAIN_REQ) begin
          s_nxt.st = ASC_RETAIN;
          s_nxt.ce_n = `ASC_IDLE_CTRL_N;
        end else if (REQ_VALID && REQ_WRITE) begin
          // Address, selects and data all set one cycle before the strobe
          s_nxt.st = ASC_WR_SETUP;
          s_nxt.addr = REQ_ADDR;
          s_nxt.wdata = REQ_WDATA;
          s_nxt.lane_n = lanes_n;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b1;
          s_nxt.we_n = 1'b1;
          s_nxt.dq_oe = 1'b1;
        end else if (REQ_VALID) begin
          // Address goes out in the same edge as the selects
          s_nxt.st = ASC_RD;
          s_nxt.addr = REQ_ADDR;
          s_nxt.lane_n = lanes_n;
          s_nxt.ce_n = 1'b0;
          s_nxt.oe_n = 1'b0;
          s_nxt.we_n = 1'b1;
          s_nxt.dq_oe = 1'b0;
          tif.load = 1'b1;
          tif.count = CNT_W'(`ASC_READ_CYC);
        end
      end
      ASC_RD: begin
        // Sample after the access time; floating lanes read as zero
        if (tif.done) begin
          s_nxt.rdata[HALF_W-1:0] = s_r.lane_n[0] ? '0 : SRAM_DQ_I[HALF_W-1:0];
          s_nxt.rdata[DATA_W-1:HALF_W] = s_r.lane_n[1] ? '0 : SRAM_DQ_I[DATA_W-1:HALF_W];
          s_nxt.rsp = 1'b1;
          s_nxt.st = ASC_RD_TURN;
          s_nxt.ce_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.lane_n = `ASC_LANES_OFF_N;
          tif.load = 1'b1;
          tif.count = CNT_W'(`ASC_TURN_CYC);
        end
      end
      ASC_RD_TURN: begin
        // The memory may still drive until its release delay has passed
        if (tif.done) begin
          s_nxt.st = ASC_IDLE;
        end
      end
      ASC_WR_SETUP: begin
        // Strobe falls only with chip and lane selects already low
        s_nxt.st = ASC_WR_PULSE;
        s_nxt.we_n = 1'b0;
        tif.load = 1'b1;
        tif.count = CNT_W'(`ASC_PULSE_CYC);
      end
      ASC_WR_PULSE: begin
        // Strobe rise ends the write; data was set up a cycle before the pulse began
        if (tif.done) begin
          s_nxt.st = ASC_WR_HOLD;
          s_nxt.we_n = 1'b1;
        end
      end
      ASC_WR_HOLD: begin
        // Address, data and chip select change only a cycle after the end,
        // so chip select never rises together with the strobe
        s_nxt.st = ASC_IDLE;
        s_nxt.ce_n = 1'b1;
        s_nxt.lane_n = `ASC_LANES_OFF_N;
        s_nxt.dq_oe = 1'b0;
        s_nxt.rsp = 1'b1;
      end
      ASC_RETAIN: begin
        // All controls held high at full level until retention ends
        if (!RETAIN_REQ) begin
          s_nxt.st = ASC_RECOVER;
          tif.load = 1'b1;
          tif.count = CNT_W'(`ASC_RECOV_CYC);
        end
      end
      ASC_RECOVER: begin
        if (tif.done) begin
          s_nxt.st = ASC_IDLE;
        end
      end
      default: begin
        s_nxt.st = ASC_IDLE;
      end
    endcase
  end

  // Single state register; reset parks every control pin high
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_r <= '{
        st: ASC_IDLE,
        addr: '0,
        wdata: '0,
        lane_n: `ASC_LANES_OFF_N,
        ce_n: `ASC_IDLE_CTRL_N,
        oe_n: `ASC_IDLE_CTRL_N,
        we_n: `ASC_IDLE_CTRL_N,
        dq_oe: 1'b0,
        rdata: '0,
        rsp: 1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign SRAM_ADDR = s_r.addr;
  assign SRAM_CHIP_SEL_N = s_r.ce_n;
  assign SRAM_OUT_DRIVE_N = s_r.oe_n;
  assign SRAM_WRITE_STROBE_N = s_r.we_n;
  assign SRAM_UPPER_BYTE_SEL_N = s_r.lane_n[1];
  assign SRAM_LOWER_BYTE_SEL_N = s_r.lane_n[0];
  assign SRAM_DQ_O = s_r.wdata;
  assign SRAM_DQ_OE = s_r.dq_oe;
  assign RSP_VALID = s_r.rsp;
  assign RSP_RDATA = s_r.rdata;
  assign RETAINING = (s_r.st == ASC_RETAIN);
endmodule : asc_ctrl
`default_nettype wire

// >>> logic/asc_cfg.svh
// Timing and reset constants for the asynchronous static memory controller.
// Assumes a single 40 MHz core clock; every count is derived from it.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// Core clock period in nanoseconds
`define ASC_CLK_PERIOD_NS 25

// Least times to honour, as printed, in nanoseconds
`define ASC_T_READ_CYCLE_NS 45
`define ASC_T_ADDR_TO_DATA_NS 45
`define ASC_T_OE_RELEASE_NS 18
`define ASC_T_WE_PULSE_NS 35
`define ASC_T_DATA_SETUP_NS 25
`define ASC_T_ADDR_TO_END_NS 35
`define ASC_T_RECOVERY_NS 45

// Least times round up to whole cycles, never below one
`define ASC_CYC(ns) ((((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS))
`define ASC_READ_CYC `ASC_CYC(`ASC_T_ADDR_TO_DATA_NS)
`define ASC_TURN_CYC `ASC_CYC(`ASC_T_OE_RELEASE_NS)
`define ASC_PULSE_CYC `ASC_CYC(`ASC_T_WE_PULSE_NS)
`define ASC_RECOV_CYC `ASC_CYC(`ASC_T_RECOVERY_NS)

// Pin levels at reset and while idle
`define ASC_IDLE_CTRL_N 1'b1
`define ASC_LANES_OFF_N 2'h3

`endif

// >>> logic/asc_pkg.sv
// Types shared by the static memory controller and its interval timer.
// Constants live in asc_cfg.svh.
package asc_pkg;
  // Gray codes along idle -> read -> turn and idle -> setup -> pulse -> hold
  typedef enum logic [2:0] {
    ASC_IDLE = 3'h0,
    ASC_RD = 3'h1,
    ASC_RD_TURN = 3'h3,
    ASC_WR_SETUP = 3'h2,
    ASC_WR_PULSE = 3'h6,
    ASC_WR_HOLD = 3'h7,
    ASC_RETAIN = 3'h5,
    ASC_RECOVER = 3'h4
  } asc_state_t;
endpackage : asc_pkg

// >>> logic/asc_tmr_if.sv
// Link between the controller state machine and its interval timer.
// Both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface asc_tmr_if #(
  parameter int CNT_W = 4
);
  logic load;
  logic [CNT_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : asc_tmr_if
`default_nettype wire

// >>> logic/asc_timer.sv
// Interval timer: a load of N keeps done low for N-1 cycles after the load,
// so a state entered on the load lasts exactly N cycles. Needs N >= 1.
`timescale 1ns/1ps
`default_nettype none
module asc_timer
  import asc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  asc_tmr_if.tmr tif
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } asc_tmr_st_t;

  asc_tmr_st_t st_r;
  asc_tmr_st_t st_nxt;

  // Reload wins over the running count
  always_comb begin
    st_nxt = st_r;
    if (tif.load) begin
      st_nxt.cnt = tif.count - CNT_W'(1);
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    end
  end

  assign tif.done = (st_r.cnt == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : asc_timer
`default_nettype wire

// >>> verif/asc_ctrl_checker.sv
// Pin timing assertions for asc_ctrl.
// Sees only the top ports; bound in below.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_checker
  import asc_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic REQ_READY,
  input wire logic RETAINING,
  input wire logic [ADDR_W-1:0] SRAM_ADDR,
  input wire logic SRAM_CHIP_SEL_N,
  input wire logic SRAM_OUT_DRIVE_N,
  input wire logic SRAM_WRITE_STROBE_N,
  input wire logic SRAM_UPPER_BYTE_SEL_N,
  input wire logic SRAM_LOWER_BYTE_SEL_N,
  input wire logic [DATA_W-1:0] SRAM_DQ_O,
  input wire logic SRAM_DQ_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // At least one lane selected
  wire logic lane = !(SRAM_UPPER_BYTE_SEL_N && SRAM_LOWER_BYTE_SEL_N);
  AST_WR_OVERLAP: assert property (
    !SRAM_WRITE_STROBE_N |-> !SRAM_CHIP_SEL_N && lane) else $error("strobe without selects");
  AST_DATA_SETUP: assert property (
    $rose(SRAM_WRITE_STROBE_N) |-> SRAM_DQ_OE && $past(SRAM_DQ_OE, 3) && $stable(SRAM_DQ_O))
    else $error("write data not held");
  // One cycle after output drive rises covers the bus release delay
  AST_NO_FIGHT: assert property (
    !SRAM_OUT_DRIVE_N || $past(!SRAM_OUT_DRIVE_N) |-> !SRAM_DQ_OE) else $error("bus contention");
  AST_PULSE: assert property (
    $fell(SRAM_WRITE_STROBE_N) |->
    (!SRAM_WRITE_STROBE_N && !SRAM_CHIP_SEL_N && lane && $stable(SRAM_ADDR))[*2])
    else $error("write pulse short");
  AST_ADDR_HOLD: assert property (
    $rose(SRAM_WRITE_STROBE_N) |-> $stable(SRAM_ADDR) && !SRAM_CHIP_SEL_N)
    else $error("address moved at write end");
  AST_READ_FORM: assert property (
    !SRAM_OUT_DRIVE_N |-> SRAM_WRITE_STROBE_N && !SRAM_CHIP_SEL_N && lane)
    else $error("bad read controls");
  AST_READ_ADDR: assert property (
    !SRAM_CHIP_SEL_N && $past(!SRAM_CHIP_SEL_N) |-> $stable(SRAM_ADDR))
    else $error("address moved while selected");
  AST_RETAIN: assert property (
    RETAINING |-> SRAM_CHIP_SEL_N && SRAM_WRITE_STROBE_N && SRAM_OUT_DRIVE_N && !lane
    && !SRAM_DQ_OE) else $error("pins active in retention");
  AST_RECOVER: assert property (
    $fell(RETAINING) |-> (SRAM_CHIP_SEL_N && !REQ_READY)[*2] ##1 REQ_READY)
    else $error("recovery not two cycles");
endmodule : asc_ctrl_checker
bind asc_ctrl asc_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) asc_ctrl_checker_i (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REQ_READY(REQ_READY), .RETAINING(RETAINING),
  .SRAM_ADDR(SRAM_ADDR), .SRAM_CHIP_SEL_N(SRAM_CHIP_SEL_N),
  .SRAM_OUT_DRIVE_N(SRAM_OUT_DRIVE_N), .SRAM_WRITE_STROBE_N(SRAM_WRITE_STROBE_N),
  .SRAM_UPPER_BYTE_SEL_N(SRAM_UPPER_BYTE_SEL_N), .SRAM_LOWER_BYTE_SEL_N(SRAM_LOWER_BYTE_SEL_N),
  .SRAM_DQ_O(SRAM_DQ_O), .SRAM_DQ_OE(SRAM_DQ_OE));
`default_nettype wire

// >>> verif/asc_sram_model.sv
// Behavioural 256K x 16 static memory with byte lanes.
// Assumes its pins are driven on the core clock.
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [1:0] sel_n,
  input wire logic [17:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mem [0:262143];
  wire logic wr = !ce_n && !we_n;
  wire logic rd = !ce_n && !oe_n && we_n;
  initial dout = 16'h5aa5;
  // A floating lane toggles so stale data never passes as a read
  always @(posedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (wr && !sel_n[b]) mem[addr][8*b +: 8] <= din[8*b +: 8];
      if (rd && !sel_n[b]) dout[8*b +: 8] <= mem[addr][8*b +: 8];
      else dout[8*b +: 8] <= ~dout[8*b +: 8];
    end
  end
endmodule : asc_sram_model
`default_nettype wire

// >>> verif/asc_ctrl_tb.sv
// Self-checking bench for asc_ctrl with a behavioural memory.
// Inputs move 2 ns after each rising edge of a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_tb
  import asc_pkg::*;
;
  typedef struct packed {
    logic w; logic [17:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] x;
  } asc_row_t;
  logic clk = 0, rst_n = 0, vld = 0, wr = 0, ret_req = 0;
  logic [17:0] adr = 0, sa;
  logic [15:0] wd = 0, rdat, dqo, dqi;
  logic [1:0] be = 0;
  logic rdy, rsp, ret, ce_n, oe_n, we_n, ub_n, lb_n, dqoe;
  int err_count = 0, samples_checked = 0, n;
  // Writes, a lane-masked write, reads of each lane mix, then a masked write and its read back
  asc_row_t rows [9] = '{{1'h1, 18'h0, 16'ha5c3, 2'h3, 16'h0},
    {1'h1, 18'h3ffff, 16'h1234, 2'h3, 16'h0}, {1'h1, 18'h0, 16'h7e00, 2'h2, 16'h0},
    {1'h0, 18'h0, 16'h0, 2'h3, 16'h7ec3}, {1'h0, 18'h0, 16'h0, 2'h1, 16'h00c3},
    {1'h0, 18'h0, 16'h0, 2'h2, 16'h7e00}, {1'h0, 18'h3ffff, 16'h0, 2'h0, 16'h1234},
    {1'h1, 18'h3ffff, 16'h5555, 2'h1, 16'h0}, {1'h0, 18'h3ffff, 16'h0, 2'h3, 16'h1255}};
  always #12.5 clk = ~clk;
  asc_ctrl asc_ctrl_i (.CORE_CLK(clk), .RESETN(rst_n), .REQ_VALID(vld), .REQ_READY(rdy),
    .REQ_WRITE(wr), .REQ_ADDR(adr), .REQ_WDATA(wd), .REQ_BE(be), .RSP_VALID(rsp),
    .RSP_RDATA(rdat), .RETAIN_REQ(ret_req), .RETAINING(ret), .SRAM_ADDR(sa),
    .SRAM_CHIP_SEL_N(ce_n), .SRAM_OUT_DRIVE_N(oe_n), .SRAM_WRITE_STROBE_N(we_n),
    .SRAM_UPPER_BYTE_SEL_N(ub_n), .SRAM_LOWER_BYTE_SEL_N(lb_n), .SRAM_DQ_O(dqo),
    .SRAM_DQ_OE(dqoe), .SRAM_DQ_I(dqi));
  asc_sram_model asc_sram_model_i (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .sel_n({ub_n, lb_n}), .addr(sa), .din(dqo), .dout(dqi));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One request held until taken, then its answer timed and checked
  task automatic xfer(input asc_row_t r);
    {wr, adr, wd, be} = {r.w, r.a, r.d, r.be};
    vld = 1;
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge clk) #2;
      n++;
    end
    chk(18'(rdy), 18'h1);
    @(posedge clk) #2;
    vld = 0;
    n = 0;
    while (rsp !== 1'b1 && n < 9) begin
      @(posedge clk) #2;
      n++;
    end
    chk(18'(n), r.w ? 18'h4 : 18'h2);
    if (!r.w) chk(rdat, r.x);
  endtask : xfer
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    #2;
    chk({ce_n, oe_n, we_n, ub_n, lb_n, dqoe, rsp, ret}, 18'hf8);
    rst_n = 1;
    foreach (rows[i]) xfer(rows[i]);
    // Retention after the last read: ready must stay low through recovery
    ret_req = 1;
    // The last read still has its turnaround cycle before retention is entered
    repeat (2) @(posedge clk);
    #2;
    chk({ret, rdy}, 18'h2);
    repeat (3) @(posedge clk);
    #2 ret_req = 0;
    n = 0;
    while (rdy !== 1'b1 && n < 9) begin
      @(posedge clk) #2;
      n++;
    end
    chk(18'(n), 18'h3);
    xfer(rows[8]);
    // Reset in the middle of a write pulse drops every control at once
    {wr, adr, wd, be, vld} = {1'h1, 18'h2, 16'hbeef, 2'h3, 1'h1};
    // Turnaround, take into setup, then the strobe falls
    repeat (3) @(posedge clk);
    #2 rst_n = 0;
    vld = 0;
    #1 chk({ce_n, oe_n, we_n, ub_n, lb_n, dqoe}, 18'h3e);
    chk(18'(rdat), 18'h0);
    @(posedge clk) #2 rst_n = 1;
    xfer(rows[3]);
    tally_and_finish();
  end
endmodule : asc_ctrl_tb
`default_nettype wire
